// [hw/mcf_pkg.sv]
/*
 * Package for the machine check frame builder: frame layout, code values,
 * field positions and the packed structs that carry the fault inputs.
 * It assumes one processor clock and that the stack write port accepts one
 * longword per cycle while its ready is high.
 */
// Function
// - Bus, cache and memory errors raise a machine check.
// - Push status, PC, four parameters, byte count.
// - Byte count longword equals sixteen.
// - One parameter is the 32-bit check code.
// - Accelerator protocol error code 1, reserved code 2.
// - Status lines 10 give 3, 01 give 4.
// - Miss with region page address gives 5 or 6.
// - Modify-bit update region address gives 7 or 8.
// - Unused priority level request gives code 9.
// - Float checks record partial completion in bit 27.
// - Restart inhibit flag goes in state two bit 15.
// - Recent address parameter is read address plus four.
package mcf_pkg;
	// Frame contents and layout.
	localparam logic [31:0] MCF_BYTE_COUNT = 32'h00000010;
	localparam int MCF_FRAME_WORDS = 7;
	localparam logic [31:0] MCF_ADDR_STEP = 32'h00000004;
	localparam int MCF_STATUS_PART_DONE_BIT = 27;
	localparam int MCF_IS2_RESTART_BIT = 15;

	// Check codes.
	localparam logic [31:0] MCF_CODE_FP_PROTOCOL = 32'h00000001;
	localparam logic [31:0] MCF_CODE_FP_RESERVED = 32'h00000002;
	localparam logic [31:0] MCF_CODE_FP_STAT_10 = 32'h00000003;
	localparam logic [31:0] MCF_CODE_FP_STAT_01 = 32'h00000004;
	localparam logic [31:0] MCF_CODE_TBM_PROGRAM = 32'h00000005;
	localparam logic [31:0] MCF_CODE_TBM_CONTROL = 32'h00000006;
	localparam logic [31:0] MCF_CODE_MOD_PROGRAM = 32'h00000007;
	localparam logic [31:0] MCF_CODE_MOD_CONTROL = 32'h00000008;
	localparam logic [31:0] MCF_CODE_UNUSED_LEVEL = 32'h00000009;
	localparam logic [31:0] MCF_CODE_READ_ERROR = 32'h00000080;
	localparam logic [31:0] MCF_CODE_WRITE_ERROR = 32'h00000082;

	// Status line patterns that the accelerator must never return.
	localparam logic [1:0] MCF_CPSTAT_BAD_HI = 2'h2;
	localparam logic [1:0] MCF_CPSTAT_BAD_LO = 2'h1;

	// Page-table address regions.
	typedef enum logic [1:0] {
		MCF_REGION_PROGRAM = 2'b00,
		MCF_REGION_CONTROL = 2'b01,
		MCF_REGION_SYSTEM = 2'b10,
		MCF_REGION_RESERVED = 2'b11
	} mcf_region_t;

	// Hardware error sources that abort the current instruction.
	typedef struct packed {
		logic data_bus_parity;
		logic cache_parity;
		logic sysbus_nonexistent_memory;
		logic sysbus_device_parity;
		logic sysbus_no_grant;
		logic data_bus_timeout;
		logic main_nonexistent_memory;
		logic main_uncorrectable;
		logic on_write;
	} mcf_bus_err_t;

	// Accelerator, memory-management and interrupt controller faults.
	typedef struct packed {
		logic fp_protocol;
		logic fp_reserved;
		logic fp_status_valid;
		logic [1:0] coprocessor_status_lines;
		logic tb_miss_walk;
		logic modify_walk;
		mcf_region_t pte_region;
		logic unused_level_request;
	} mcf_fault_t;

	// Processor state captured with the check.
	typedef struct packed {
		logic [31:0] processor_status_longword;
		logic [31:0] pc;
		logic [31:0] access_address;
		logic [31:0] state_info1;
		logic [31:0] state_info2;
		logic part_done;
		logic restart_inhibit_flag;
	} mcf_state_t;
endpackage

// [hw/mcf_code_sel.sv]
/*
 * Combinational classifier that turns the fault inputs into one check code.
 * It assumes the inputs are stable during the cycle that they are sampled.
 */
`timescale 1ns/100ps
`default_nettype none
module mcf_code_sel (
	// Fault sources.
	input wire mcf_pkg::mcf_bus_err_t bus_err,
	input wire mcf_pkg::mcf_fault_t fault,
	// Classification.
	output logic hit,
	output logic fp_class,
	output logic [31:0] code
);
	import mcf_pkg::*;

	// Named decode terms.
	wire bus_any = |bus_err[8:1];
	wire st_hi = fault.fp_status_valid &&
		fault.coprocessor_status_lines == MCF_CPSTAT_BAD_HI;
	wire st_lo = fault.fp_status_valid &&
		fault.coprocessor_status_lines == MCF_CPSTAT_BAD_LO;
	wire is_prog = fault.pte_region == MCF_REGION_PROGRAM;
	wire is_ctl = fault.pte_region == MCF_REGION_CONTROL;
	wire tbm = fault.tb_miss_walk && (is_prog || is_ctl);
	wire mdw = fault.modify_walk && (is_prog || is_ctl);

	assign fp_class = fault.fp_protocol || fault.fp_reserved ||
		st_hi || st_lo;
	assign hit = bus_any || fp_class || tbm || mdw ||
		fault.unused_level_request;

	// Fixed priority: accelerator, then walk faults, level, bus errors.
	always_comb begin
		code = 32'h00000000;
		if (fault.fp_protocol) begin
			code = MCF_CODE_FP_PROTOCOL;
		end else if (fault.fp_reserved) begin
			code = MCF_CODE_FP_RESERVED;
		end else if (st_hi) begin
			code = MCF_CODE_FP_STAT_10;
		end else if (st_lo) begin
			code = MCF_CODE_FP_STAT_01;
		end else if (tbm) begin
			code = is_prog ? MCF_CODE_TBM_PROGRAM : MCF_CODE_TBM_CONTROL;
		end else if (mdw) begin
			code = is_prog ? MCF_CODE_MOD_PROGRAM : MCF_CODE_MOD_CONTROL;
		end else if (fault.unused_level_request) begin
			code = MCF_CODE_UNUSED_LEVEL;
		end else if (bus_any) begin
			code = bus_err.on_write ? MCF_CODE_WRITE_ERROR :
				MCF_CODE_READ_ERROR;
		end
	end
endmodule
`default_nettype wire

// [hw/mcf_frame_builder.sv]
/*
 * Machine check frame builder. On a fault it latches processor state and
 * writes the seven-longword frame down the stack, deepest word first, so
 * the byte count ends on top. It assumes the stack port takes one word per
 * cycle when stack_ready is high and that the sequencer holds the
 * instruction while busy is high.
 */
`timescale 1ns/100ps
`default_nettype none
module mcf_frame_builder (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Fault sources and captured state.
	input wire mcf_pkg::mcf_bus_err_t bus_err,
	input wire mcf_pkg::mcf_fault_t fault,
	input wire mcf_pkg::mcf_state_t cpu_state,
	input wire logic [31:0] stack_pointer,
	// Stack write port.
	input wire logic stack_ready,
	output logic stack_we,
	output logic [31:0] stack_addr,
	output logic [31:0] stack_data,
	// Sequencer handshake.
	output logic abort_req,
	output logic busy,
	output logic done,
	output logic [31:0] new_stack_pointer
);
	import mcf_pkg::*;

	// Builder states.
	typedef enum logic [1:0] {
		MCF_IDLE = 2'b00,
		MCF_PUSH = 2'b01,
		MCF_DONE = 2'b10
	} mcf_fsm_t;

	mcf_fsm_t state; // Current state.
	mcf_fsm_t next_state; // Next state.
	logic [2:0] idx; // Next frame slot to write, 6 deepest.
	logic [31:0] frame [0:MCF_FRAME_WORDS-1]; // Latched frame, 0 on top.
	logic [31:0] sp; // Working stack address.
	wire hit; // A fault is present.
	wire fp_class; // The fault is an accelerator error.
	wire [31:0] code; // Selected check code.

	// Fault classification.
	mcf_code_sel u_sel (
		.bus_err(bus_err),
		.fault(fault),
		.hit(hit),
		.fp_class(fp_class),
		.code(code)
	);

	// Status word with the partial-completion flag inserted for float checks.
	function automatic logic [31:0] fix_status(input logic [31:0] p,
		input logic fp, input logic pd);
		logic [31:0] r;
		r = p;
		if (fp) begin
			r[MCF_STATUS_PART_DONE_BIT] = pd;
		end
		return r;
	endfunction

	wire [31:0] is2 = {cpu_state.state_info2[31:16],
		cpu_state.restart_inhibit_flag, cpu_state.state_info2[14:0]};
	wire start = state == MCF_IDLE && hit;
	wire push = state == MCF_PUSH && stack_ready;
	wire last = idx == 3'h0;
	wire [31:0] slot_addr = sp - MCF_ADDR_STEP;

	// Next-state decode.
	always_comb begin
		next_state = state;
		unique case (state)
			MCF_IDLE: begin
				if (hit) begin
					next_state = MCF_PUSH;
				end
			end
			MCF_PUSH: begin
				if (push && last) begin
					next_state = MCF_DONE;
				end
			end
			MCF_DONE: begin
				next_state = MCF_IDLE;
			end
			default: begin
				next_state = MCF_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= MCF_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Frame latch; slot order fixes the stack layout.
	always_ff @(posedge mclk) begin
		if (start) begin
			frame[0] <= MCF_BYTE_COUNT;
			frame[1] <= code;
			frame[2] <= cpu_state.access_address + MCF_ADDR_STEP;
			frame[3] <= cpu_state.state_info1;
			frame[4] <= is2;
			frame[5] <= cpu_state.pc;
			frame[6] <= fix_status(cpu_state.processor_status_longword,
				fp_class, cpu_state.part_done);
		end
	end

	// Push sequencing: one longword per accepted cycle, deepest first.
	always_ff @(posedge mclk) begin
		if (rst) begin
			idx <= 3'h0;
			sp <= 32'h00000000;
		end else if (start) begin
			idx <= 3'(MCF_FRAME_WORDS - 1);
			sp <= stack_pointer;
		end else if (push) begin
			idx <= idx - 3'h1;
			sp <= slot_addr;
		end
	end

	// Registered outputs.
	always_ff @(posedge mclk) begin
		if (rst) begin
			stack_we <= 1'b0;
			stack_addr <= 32'h00000000;
			stack_data <= 32'h00000000;
			abort_req <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			new_stack_pointer <= 32'h00000000;
		end else begin
			stack_we <= push;
			stack_addr <= slot_addr;
			// Data only moves on a write, so the unlatched frame never shows.
			if (push) begin
				stack_data <= frame[idx];
			end
			abort_req <= start;
			busy <= next_state != MCF_IDLE;
			done <= push && last;
			if (push && last) begin
				new_stack_pointer <= slot_addr;
			end
		end
	end

	// Assertions.
	a_frame_count_top: assert property (@(posedge mclk) disable iff (rst)
		(push && last) |=> stack_data == MCF_BYTE_COUNT)
		else $error("Top of frame is not the byte count");
	a_frame_psl_deep: assert property (@(posedge mclk) disable iff (rst)
		start ##1 push |=> stack_data == $past(frame[6]))
		else $error("First pushed word is not the status word");
	a_code_fp_proto: assert property (@(posedge mclk) disable iff (rst)
		(start && fault.fp_protocol) |=> frame[1] == MCF_CODE_FP_PROTOCOL)
		else $error("Protocol error code wrong");
	a_code_status_hi: assert property (@(posedge mclk) disable iff (rst)
		(start && !fault.fp_protocol && !fault.fp_reserved &&
		fault.fp_status_valid && fault.coprocessor_status_lines == 2'h2)
		|=> frame[1] == MCF_CODE_FP_STAT_10)
		else $error("Status 10 code wrong");
	a_code_unused_lvl: assert property (@(posedge mclk) disable iff (rst)
		(start && fault.unused_level_request && !fp_class &&
		!fault.tb_miss_walk && !fault.modify_walk)
		|=> frame[1] == MCF_CODE_UNUSED_LEVEL)
		else $error("Unused level code wrong");
	a_abort_on_bus: assert property (@(posedge mclk) disable iff (rst)
		(state == MCF_IDLE && |bus_err[8:1]) |=> abort_req)
		else $error("Bus error did not abort");
	a_push_seven: assert property (@(posedge mclk) disable iff (rst)
		start |=> idx == 3'h6 && sp == $past(stack_pointer))
		else $error("Frame push not set up for seven words");
	a_addr_plus_four: assert property (@(posedge mclk) disable iff (rst)
		start |=> frame[2] == $past(cpu_state.access_address) + 32'h4)
		else $error("Recent address not plus four");
	a_restart_bit: assert property (@(posedge mclk) disable iff (rst)
		start |=> frame[4][15] == $past(cpu_state.restart_inhibit_flag))
		else $error("Restart inhibit bit not captured");
	a_part_done: assert property (@(posedge mclk) disable iff (rst)
		(start && fp_class) |=> frame[6][27] == $past(cpu_state.part_done))
		else $error("Partial completion bit not recorded");
	a_code_walk_prog: assert property (@(posedge mclk) disable iff (rst)
		(start && !fp_class && fault.tb_miss_walk &&
		fault.pte_region == MCF_REGION_PROGRAM) |=>
		frame[1] == MCF_CODE_TBM_PROGRAM)
		else $error("Walk code region mismatch");
	a_code_mod_ctl: assert property (@(posedge mclk) disable iff (rst)
		(start && !fp_class && !fault.tb_miss_walk && fault.modify_walk &&
		fault.pte_region == MCF_REGION_CONTROL) |=>
		frame[1] == MCF_CODE_MOD_CONTROL)
		else $error("Modify code region mismatch");
	a_code_present: assert property (@(posedge mclk) disable iff (rst)
		start |=> frame[1] != 32'h0)
		else $error("Check code missing");

	c_fp_check: cover property (@(posedge mclk) start && fp_class);
	c_bus_check: cover property (@(posedge mclk) start && |bus_err[8:1]);
	c_stall_push: cover property (@(posedge mclk)
		state == MCF_PUSH && !stack_ready);
	c_frame_done: cover property (@(posedge mclk) done);
endmodule
`default_nettype wire

// [test/mcf_frame_builder_bench.sv]
/*
 * Self-checking bench for the machine check frame builder. Each fault kind
 * is raised with random processor state and a random stack pointer, and
 * the seven words of the frame are collected and checked.
 * It assumes the builder stands alone on one clock; the bench drives the
 * fault inputs and the stack ready line itself.
 */
`timescale 1ns/100ps
`default_nettype none
module mcf_frame_builder_bench;
	import mcf_pkg::*;
	// Clock, reset and design inputs.
	logic mclk = 1'b0;
	logic rst = 1'b1;
	mcf_bus_err_t bus_err = '0;
	mcf_fault_t fault = '0;
	mcf_state_t cpu_state = '0;
	logic [31:0] stack_pointer = 32'h00000000;
	logic stack_ready = 1'b0;
	logic stall_on = 1'b0;
	// Design outputs.
	logic stack_we, abort_req, busy, done;
	logic [31:0] stack_addr, stack_data, new_stack_pointer;
	// Counters and collected frame words.
	int fails = 0;
	int samples_checked = 0;
	int aborts = 0;
	logic [31:0] got_a[$];
	logic [31:0] got_w[$];
	logic got_d[$];

	mcf_frame_builder i_mcf_frame_builder (
		.mclk(mclk), .rst(rst), .bus_err(bus_err), .fault(fault),
		.cpu_state(cpu_state), .stack_pointer(stack_pointer),
		.stack_ready(stack_ready), .stack_we(stack_we),
		.stack_addr(stack_addr), .stack_data(stack_data),
		.abort_req(abort_req), .busy(busy), .done(done),
		.new_stack_pointer(new_stack_pointer)
	);

	// The clock toggles every 10 ns, a period of 20 ns.
	always #10 mclk = ~mclk;

	// The stack stalls at random once stalling is switched on.
	always @(posedge mclk) begin
		stack_ready <= !stall_on || ($urandom_range(2) != 0);
	end

	// Every stack write and every abort pulse is recorded.
	always @(posedge mclk) begin
		if (stack_we === 1'b1) begin
			got_a.push_back(stack_addr);
			got_w.push_back(stack_data);
			got_d.push_back(done);
		end
		if (abort_req === 1'b1) begin
			aborts++;
		end
	end

	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Compares one longword.
	task automatic check_word(input logic [31:0] g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// Compares one flag.
	task automatic check_bit(input logic g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t %s got %b exp %b", $time, m, g, e);
		end
	endtask

	// Expected check code, highest priority source first.
	function automatic logic [31:0] exp_code(mcf_bus_err_t b, mcf_fault_t f);
		if (f.fp_protocol) return MCF_CODE_FP_PROTOCOL;
		if (f.fp_reserved) return MCF_CODE_FP_RESERVED;
		if (f.fp_status_valid &&
			f.coprocessor_status_lines == MCF_CPSTAT_BAD_HI)
			return MCF_CODE_FP_STAT_10;
		if (f.fp_status_valid &&
			f.coprocessor_status_lines == MCF_CPSTAT_BAD_LO)
			return MCF_CODE_FP_STAT_01;
		if (f.tb_miss_walk) return (f.pte_region == MCF_REGION_PROGRAM) ?
			MCF_CODE_TBM_PROGRAM : MCF_CODE_TBM_CONTROL;
		if (f.modify_walk) return (f.pte_region == MCF_REGION_PROGRAM) ?
			MCF_CODE_MOD_PROGRAM : MCF_CODE_MOD_CONTROL;
		if (f.unused_level_request) return MCF_CODE_UNUSED_LEVEL;
		return b.on_write ? MCF_CODE_WRITE_ERROR : MCF_CODE_READ_ERROR;
	endfunction

	// Raises fault kind k, offers a late fault while busy, checks the frame.
	task automatic run_frame(input int k);
		mcf_bus_err_t b;
		mcf_fault_t f;
		mcf_state_t s;
		logic [31:0] sp, c, e;
		int n;
		b = '0;
		f = '0;
		case (k)
			0: f.fp_protocol = 1'b1;
			1: f.fp_reserved = 1'b1;
			2, 3: begin
				f.fp_status_valid = 1'b1;
				f.coprocessor_status_lines = (k == 2) ? 2'h2 : 2'h1;
			end
			4, 5, 6, 7: begin
				f.tb_miss_walk = (k < 6);
				f.modify_walk = (k >= 6);
				f.pte_region = k[0] ? MCF_REGION_CONTROL : MCF_REGION_PROGRAM;
			end
			8: f.unused_level_request = 1'b1;
			default: begin
				b = 9'(2 << $urandom_range(7));
				b.on_write = (k == 10);
				f.fp_reserved = (k == 11);
				f.unused_level_request = (k == 11);
			end
		endcase
		s = {$urandom, $urandom, $urandom, $urandom, $urandom, 2'($urandom)};
		sp = $urandom & 32'hFFFFFFFC;
		c = exp_code(b, f);
		got_a.delete();
		got_w.delete();
		got_d.delete();
		aborts = 0;
		@(posedge mclk);
		bus_err <= b;
		fault <= f;
		cpu_state <= s;
		stack_pointer <= sp;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (abort_req !== 1'b1 && n < 20);
		check_bit(abort_req, 1'b1, "abort");
		check_bit(busy, 1'b1, "busy");
		// A late unused level request and new state arrive while the frame is built.
		@(posedge mclk);
		bus_err <= '0;
		fault <= 10'h001;
		cpu_state <= ~s;
		#1 check_bit(abort_req, 1'b0, "pulse");
		@(posedge mclk);
		fault <= '0;
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 200) begin
			fails++;
			$display("MISMATCH %0t busy never fell", $time);
			finish_test();
		end
		check_word(32'(got_a.size()), 32'h00000007, "count");
		check_word(32'(aborts), 32'h00000001, "aborts");
		for (int i = 0; i < 7; i++) begin
			check_word(got_a[i], sp - 32'(4 * (i + 1)), "addr");
			check_bit(got_d[i], i == 6, "done");
		end
		e = s.processor_status_longword;
		if (c <= MCF_CODE_FP_STAT_01) e[MCF_STATUS_PART_DONE_BIT] = s.part_done;
		check_word(got_w[0], e, "status");
		check_word(got_w[1], s.pc, "pc");
		e = s.state_info2;
		e[MCF_IS2_RESTART_BIT] = s.restart_inhibit_flag;
		check_word(got_w[2], e, "state2");
		check_word(got_w[3], s.state_info1, "state1");
		check_word(got_w[4], s.access_address + 32'h4, "vaddr");
		check_word(got_w[5], c, "code");
		check_word(got_w[6], 32'h00000010, "bytes");
		check_word(new_stack_pointer, sp - 32'h1C, "newsp");
	endtask

	// Main sequence: reset, then every fault kind with and without stalls.
	initial begin
		void'($urandom(95111));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		for (int r = 0; r < 3; r++) begin
			stall_on <= (r != 0);
			for (int k = 0; k < 12; k++) begin
				run_frame(k);
			end
		end
		finish_test();
	end
endmodule
`default_nettype wire
